/* File: spi_config_status.sv */
// configuration and status register of the serial port, wishbone slave
//
// The implementer's own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
module spi_config_status (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        link_clk_i,
  // wishbone classic slave
  input  wire logic [3:0]  adr_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  input  wire logic        we_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic        stb_i,
  input  wire logic        cyc_i,
  output logic             ack_o,
  // serial pins
  input  wire logic        sck_pin_i,
  input  wire logic        nss_pin_i,
  input  wire logic        mosi_pin_i,
  output logic             sck_o,
  output logic             sck_oe_o,
  // shifter side, same clock
  input  wire logic        tx_pending_i,
  input  wire logic        tx_load_i,
  input  wire logic        rx_read_i,
  input  wire logic        sck_edge_next_i,
  output logic             master_sample_o,
  output logic      [7:0]  rx_byte_o,
  output logic             rx_valid_o,
  output logic             master_role_o,
  output logic             clock_phase_o,
  output logic             clock_polarity_o,
  output logic             port_enable_o
);

  // ---------------- register state ----------------
  logic       master_role_select_q;
  logic       clock_phase_select_q;
  logic       clock_polarity_select_q;
  logic       port_enable_bit_q;
  logic       selected_flag_q;
  logic [1:0] deglitch_cnt_q;
  logic       shifter_empty_flag_q;
  logic       rx_buffer_empty_flag_q;
  logic       ack_q;
  logic [31:0] dat_q;
  logic       sck_level_q;
  logic [1:0] link_tgl_q;
  logic [7:0] rx_byte_q;
  logic       rx_valid_q;

  // ---------------- crossings ----------------
  logic       link_rst;
  logic       edge_tgl;
  logic       byte_tgl;
  logic [7:0] link_rx_byte;
  logic       slave_active;
  logic [1:0] sys_in;
  logic [1:0] sys_sync;
  logic       nss_s;
  logic       edge_tgl_s;
  logic       byte_tgl_s;

  // reset reaches the link domain through its own synchroniser
  spi_sync2 #(.WIDTH(1)) u_link_rst_sync (
    .clk_i (link_clk_i),
    .rst_i (1'h0),
    .d_i   (rst_i),
    .q_o   (link_rst)
  );

  spi_link_rx u_link (
    .link_clk_i (link_clk_i),
    .link_rst_i (link_rst),
    .sck_pin_i  (sck_pin_i),
    .nss_pin_i  (nss_pin_i),
    .mosi_pin_i (mosi_pin_i),
    .phase_i    (clock_phase_select_q),
    .polarity_i (clock_polarity_select_q),
    .slave_en_i (slave_active),
    .edge_tgl_o (edge_tgl),
    .byte_tgl_o (byte_tgl),
    .rx_byte_o  (link_rx_byte)
  );

  // select is not reset, so it reads idle (high) at once after reset instead of looking selected
  spi_sync2 #(.WIDTH(1)) u_nss_sync (
    .clk_i (clk_i),
    .rst_i (1'h0),
    .d_i   (nss_pin_i),
    .q_o   (nss_s)
  );

  assign sys_in = {edge_tgl, byte_tgl};

  spi_sync2 #(.WIDTH(2)) u_sys_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (sys_in),
    .q_o   (sys_sync)
  );

  assign {edge_tgl_s, byte_tgl_s} = sys_sync;

  // ---------------- decode ----------------
  wire bus_req      = cyc_i & stb_i;
  wire new_req      = bus_req & ~ack_q;
  wire hit_cfg      = (adr_i == spi_cfg_pkg::CFG_STATUS_OFFSET);
  wire hit_ctrl     = (adr_i == spi_cfg_pkg::CONTROL_OFFSET);
  wire wr_lane0     = new_req & we_i & sel_i[0];
  wire wr_cfg       = wr_lane0 & hit_cfg;
  wire wr_ctrl      = wr_lane0 & hit_ctrl;
  assign slave_active = port_enable_bit_q & ~master_role_select_q;
  wire master_on    = port_enable_bit_q & master_role_select_q;

  // toggles from the link domain become one-cycle events
  wire sck_event  = edge_tgl_s ^ link_tgl_q[1];
  wire byte_event = byte_tgl_s ^ link_tgl_q[0];

  // a byte end sets shifter empty only with no transmit pending and the receive buffer empty
  wire shifter_set   = slave_active & byte_event & ~tx_pending_i & rx_buffer_empty_flag_q;
  wire shifter_clear = tx_load_i | sck_event;
  wire rx_set_empty  = rx_read_i;
  wire rx_clear      = byte_event & slave_active;

  // master mode hides slave-only status
  wire shifter_empty_rd = shifter_empty_flag_q | master_role_select_q;
  wire rx_empty_rd      = rx_buffer_empty_flag_q | master_role_select_q;

  wire [7:0] cfg_word = {1'h0,
                         master_role_select_q,
                         clock_phase_select_q,
                         clock_polarity_select_q,
                         selected_flag_q,
                         nss_s,
                         shifter_empty_rd,
                         rx_empty_rd};
  wire [7:0] ctrl_word = {7'h00, port_enable_bit_q};

  wire [31:0] rd_word = hit_cfg  ? {24'h000000, cfg_word} :
                        hit_ctrl ? {24'h000000, ctrl_word} :
                                   32'h00000000;

  // ---------------- wishbone answer ----------------
  // every access, mapped or not, is acked one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'h0;
      dat_q <= 32'h00000000;
    end else begin
      ack_q <= new_req;
      if (new_req && !we_i) begin
        dat_q <= rd_word;
      end
    end
  end

  assign ack_o = ack_q;
  assign dat_o = dat_q;

  // ---------------- configuration ----------------
  // phase and polarity are taken even while enabled; software must stop the port first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      master_role_select_q    <= spi_cfg_pkg::CFG_STATUS_RESET[spi_cfg_pkg::MASTER_BIT];
      clock_phase_select_q    <= spi_cfg_pkg::CFG_STATUS_RESET[spi_cfg_pkg::PHASE_BIT];
      clock_polarity_select_q <= spi_cfg_pkg::CFG_STATUS_RESET[spi_cfg_pkg::POLARITY_BIT];
    end else if (wr_cfg) begin
      master_role_select_q    <= dat_i[spi_cfg_pkg::MASTER_BIT];
      clock_phase_select_q    <= dat_i[spi_cfg_pkg::PHASE_BIT];
      clock_polarity_select_q <= dat_i[spi_cfg_pkg::POLARITY_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_enable_bit_q <= spi_cfg_pkg::PORT_ENABLE_RESET;
    end else if (wr_ctrl) begin
      port_enable_bit_q <= dat_i[spi_cfg_pkg::PORT_ENABLE_BIT];
    end
  end

  // ---------------- selected flag de-glitch ----------------
  // the flag flips only after the pin has disagreed for four cycles in a row
  wire sel_differs = (~nss_s) != selected_flag_q;
  wire sel_flip    = sel_differs & (deglitch_cnt_q == spi_cfg_pkg::DEGLITCH_LAST);

  always_ff @(posedge clk_i) begin
    if (rst_i || !sel_differs) begin
      deglitch_cnt_q <= 2'h0;
    end else begin
      deglitch_cnt_q <= sel_flip ? 2'h0 : deglitch_cnt_q + 2'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      selected_flag_q <= spi_cfg_pkg::CFG_STATUS_RESET[spi_cfg_pkg::SELECTED_BIT];
    end else if (sel_flip) begin
      selected_flag_q <= ~nss_s;
    end
  end

  // ---------------- slave status flags ----------------
  // the byte end wins in both flags, setting shifter empty and clearing rx empty, so a byte end is never lost
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shifter_empty_flag_q <= spi_cfg_pkg::CFG_STATUS_RESET[spi_cfg_pkg::SHIFT_EMPTY_BIT];
    end else if (shifter_set) begin
      shifter_empty_flag_q <= 1'h1;
    end else if (shifter_clear) begin
      shifter_empty_flag_q <= 1'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_buffer_empty_flag_q <= spi_cfg_pkg::CFG_STATUS_RESET[spi_cfg_pkg::RX_EMPTY_BIT];
    end else if (rx_clear) begin
      rx_buffer_empty_flag_q <= 1'h0;
    end else if (rx_set_empty) begin
      rx_buffer_empty_flag_q <= 1'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_tgl_q <= 2'h0;
    end else begin
      link_tgl_q <= {edge_tgl_s, byte_tgl_s};
    end
  end

  // link byte changed with the toggle and stays stable for a whole byte time after the event arrives
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_byte_q  <= 8'h00;
      rx_valid_q <= 1'h0;
    end else begin
      rx_valid_q <= rx_clear;
      if (rx_clear) begin
        rx_byte_q <= link_rx_byte;
      end
    end
  end

  assign rx_byte_o  = rx_byte_q;
  assign rx_valid_o = rx_valid_q;

  // ---------------- master clock ----------------
  // sck_edge_next_i comes one cycle ahead of each clock edge from the rate divider
  wire next_is_leading = (sck_level_q == clock_polarity_select_q);
  wire next_is_sample  = next_is_leading ^ clock_phase_select_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_level_q <= 1'h0;
    end else if (!master_on) begin
      sck_level_q <= clock_polarity_select_q;
    end else if (sck_edge_next_i) begin
      sck_level_q <= ~sck_level_q;
    end
  end

  // sampling just before the inactive edge gives the slave the longest settling time
  assign master_sample_o  = master_on & sck_edge_next_i & ~next_is_sample;
  assign sck_o            = sck_level_q;
  assign sck_oe_o         = master_on;
  assign master_role_o    = master_role_select_q;
  assign clock_phase_o    = clock_phase_select_q;
  assign clock_polarity_o = clock_polarity_select_q;
  assign port_enable_o    = port_enable_bit_q;

  // ---------------- checks ----------------
  sequence s_pin_low4;
    (!nss_s)[*4];
  endsequence

  sequence s_pin_high4;
    (nss_s)[*4];
  endsequence

  a_ack_single : assert property (@(posedge clk_i) disable iff (rst_i)
    new_req |=> ack_o ##1 !ack_o)
    else $error("ack not a single cycle after request");

  a_master_drives_clk : assert property (@(posedge clk_i) disable iff (rst_i)
    sck_oe_o == (master_role_select_q && port_enable_bit_q))
    else $error("clock enable does not follow master role");

  a_idle_polarity : assert property (@(posedge clk_i) disable iff (rst_i)
    !master_on ##1 !master_on |-> sck_o == $past(clock_polarity_select_q))
    else $error("idle clock level differs from polarity");

  a_empty_set : assert property (@(posedge clk_i) disable iff (rst_i)
    shifter_set |=> shifter_empty_flag_q)
    else $error("shifter empty not set after byte");

  a_empty_clear : assert property (@(posedge clk_i) disable iff (rst_i)
    shifter_clear && !shifter_set |=> !shifter_empty_flag_q)
    else $error("shifter empty not cleared");

  a_empty_master : assert property (@(posedge clk_i) disable iff (rst_i)
    new_req && !we_i && hit_cfg && master_role_select_q |=> dat_o[spi_cfg_pkg::SHIFT_EMPTY_BIT])
    else $error("shifter empty read 0 in master mode");

  a_sel_follows : assert property (@(posedge clk_i) disable iff (rst_i)
    s_pin_low4 |=> selected_flag_q)
    else $error("selected flag missed a steady select");

  a_sel_release : assert property (@(posedge clk_i) disable iff (rst_i)
    s_pin_high4 |=> !selected_flag_q)
    else $error("selected flag missed a steady deselect");

  a_sel_glitch : assert property (@(posedge clk_i) disable iff (rst_i)
    !selected_flag_q && nss_s |=> !selected_flag_q)
    else $error("selected flag moved without a low pin");

  a_master_sample : assert property (@(posedge clk_i) disable iff (rst_i)
    master_sample_o |=> (sck_o != $past(sck_o)) && (sck_o == clock_polarity_select_q) ^ clock_phase_select_q)
    else $error("master sample not one cycle before the inactive edge");

  a_rx_handover : assert property (@(posedge clk_i) disable iff (rst_i)
    rx_clear |=> rx_valid_o && !rx_buffer_empty_flag_q && (rx_byte_o == $past(link_rx_byte)))
    else $error("received byte not handed over");

  a_status_master : assert property (@(posedge clk_i) disable iff (rst_i)
    master_role_select_q |-> cfg_word[spi_cfg_pkg::SHIFT_EMPTY_BIT] && cfg_word[spi_cfg_pkg::RX_EMPTY_BIT])
    else $error("slave-only status not forced in master mode");

  a_sel_steady : assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(selected_flag_q) |-> $past(deglitch_cnt_q) == spi_cfg_pkg::DEGLITCH_LAST)
    else $error("selected flag moved before the filter ran out");

endmodule : spi_config_status
`default_nettype wire

/* File: spi_cfg_pkg.sv */
// shared constants for the serial port configuration and status block
package spi_cfg_pkg;

  // wishbone register byte offsets
  localparam logic [3:0] CFG_STATUS_OFFSET = 4'h0;
  localparam logic [3:0] CONTROL_OFFSET    = 4'h4;

  // config/status field positions
  localparam int BUSY_BIT        = 7;
  localparam int MASTER_BIT      = 6;
  localparam int PHASE_BIT       = 5;
  localparam int POLARITY_BIT    = 4;
  localparam int SELECTED_BIT    = 3;
  localparam int SELECT_RAW_BIT  = 2;
  localparam int SHIFT_EMPTY_BIT = 1;
  localparam int RX_EMPTY_BIT    = 0;

  // control field positions
  localparam int PORT_ENABLE_BIT = 0;

  // values after reset
  localparam logic [7:0] CFG_STATUS_RESET  = 8'h07;
  localparam logic       PORT_ENABLE_RESET = 1'h0;

  // de-glitch filter on the slave select input, in system clocks
  localparam logic [1:0] DEGLITCH_LAST = 2'h3;

  // bits per serial byte, as the last bit index
  localparam logic [2:0] LAST_BIT_INDEX = 3'h7;

endpackage : spi_cfg_pkg

/* File: spi_sync2.sv */
// two flip-flop level synchroniser
`timescale 1ns/100ps
`default_nettype none
module spi_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // meta_q feeds sync_q and nothing else
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;

endmodule : spi_sync2
`default_nettype wire

/* File: spi_link_rx.sv */
// link-clock side: oversamples the serial pins, samples data, flags clock edges
`timescale 1ns/100ps
`default_nettype none
module spi_link_rx (
  input  wire logic       link_clk_i,
  input  wire logic       link_rst_i,
  input  wire logic       sck_pin_i,
  input  wire logic       nss_pin_i,
  input  wire logic       mosi_pin_i,
  input  wire logic       phase_i,
  input  wire logic       polarity_i,
  input  wire logic       slave_en_i,
  output logic            edge_tgl_o,
  output logic            byte_tgl_o,
  output logic      [7:0] rx_byte_o
);

  logic [5:0] sync_in;
  logic [5:0] sync_out;
  logic       sck_s;
  logic       nss_s;
  logic       mosi_s;
  logic       pha_l;
  logic       pol_l;
  logic       en_l;
  logic       sck_q;
  logic [2:0] bit_cnt_q;
  logic [6:0] shift_q;
  logic       edge_tgl_q;
  logic       byte_tgl_q;
  logic [7:0] rx_byte_q;

  // configuration is quasi-static, so a level crossing is enough
  assign sync_in = {sck_pin_i, nss_pin_i, mosi_pin_i, phase_i, polarity_i, slave_en_i};

  spi_sync2 #(.WIDTH(6)) u_pin_sync (
    .clk_i (link_clk_i),
    .rst_i (link_rst_i),
    .d_i   (sync_in),
    .q_o   (sync_out)
  );

  assign {sck_s, nss_s, mosi_s, pha_l, pol_l, en_l} = sync_out;

  wire active       = en_l & ~nss_s;
  wire sck_edge     = sck_s ^ sck_q;
  wire leading_edge = sck_edge & (sck_q == pol_l);
  wire sample_now   = active & (pha_l ? (sck_edge & ~leading_edge) : leading_edge);
  wire last_bit     = (bit_cnt_q == spi_cfg_pkg::LAST_BIT_INDEX);

  always_ff @(posedge link_clk_i) begin
    if (link_rst_i) begin
      sck_q <= 1'h0;
    end else begin
      sck_q <= sck_s;
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (link_rst_i || !active) begin
      bit_cnt_q <= 3'h0;
      shift_q   <= 7'h00;
    end else if (sample_now) begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      shift_q   <= {shift_q[5:0], mosi_s};
    end
  end

  // rx byte stays put for a whole byte time, long after the toggle is seen
  always_ff @(posedge link_clk_i) begin
    if (link_rst_i) begin
      byte_tgl_q <= 1'h0;
      rx_byte_q  <= 8'h00;
    end else if (sample_now && last_bit) begin
      byte_tgl_q <= ~byte_tgl_q;
      rx_byte_q  <= {shift_q, mosi_s};
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (link_rst_i) begin
      edge_tgl_q <= 1'h0;
    end else if (active && sck_edge) begin
      edge_tgl_q <= ~edge_tgl_q;
    end
  end

  assign edge_tgl_o = edge_tgl_q;
  assign byte_tgl_o = byte_tgl_q;
  assign rx_byte_o  = rx_byte_q;

  a_sample_edge : assert property (@(posedge link_clk_i) disable iff (link_rst_i)
    sample_now |-> sck_edge && (leading_edge == !pha_l))
    else $error("data sampled on the wrong clock edge");

endmodule : spi_link_rx
`default_nettype wire

/* File: spi_master_model.sv */
// behavioural spi master that drives the port's serial pins
`timescale 1ns/100ps
`default_nettype none
module spi_master_model #(
  parameter int HALF_NS = 1000
) (
  output logic sck_o,
  output logic nss_n_o,
  output logic mosi_o
);
  initial begin
    sck_o   = 1'b0;
    nss_n_o = 1'b1;
    mosi_o  = 1'b1;
  end

  // clock parks at the idle level before select falls
  task automatic select_dev(input logic pol);
    sck_o = pol;
    #(HALF_NS);
    nss_n_o = 1'b0;
    #(HALF_NS);
  endtask : select_dev

  // a released data line shows the inverse of its last level
  task automatic deselect;
    nss_n_o = 1'b1;
    mosi_o  = ~mosi_o;
    #(HALF_NS);
  endtask : deselect

  // msb first; slow against the system clock so every edge is seen
  task automatic xfer(input logic [7:0] b, input logic ph, input logic pol);
    for (int i = 7; i >= 0; i--) begin
      #(HALF_NS / 2);
      if (!ph) mosi_o = b[i];
      #(HALF_NS / 2);
      sck_o = ~pol;
      #(HALF_NS / 2);
      if (ph) mosi_o = b[i];
      #(HALF_NS / 2);
      sck_o = pol;
    end
  endtask : xfer
endmodule : spi_master_model
`default_nettype wire

/* File: spi_config_status_bits_bench.sv */
// self-checking bench for the serial port configuration and status register
`timescale 1ns/100ps
`default_nettype none
module spi_config_status_bits_bench;
  localparam logic [3:0] CFG  = spi_cfg_pkg::CFG_STATUS_OFFSET;
  localparam logic [3:0] CTRL = spi_cfg_pkg::CONTROL_OFFSET;

  logic        clk_i      = 1'b0;
  logic        link_clk   = 1'b0;
  logic        rst        = 1'b1;
  logic [3:0]  adr        = 4'h0;
  logic [31:0] dat_w      = 32'h0;
  logic        we         = 1'b0;
  logic [3:0]  sel        = 4'h0;
  logic        stb        = 1'b0;
  logic        cyc        = 1'b0;
  logic        tx_pending = 1'b0;
  logic        tx_load    = 1'b0;
  logic        rx_read    = 1'b0;
  logic        edge_next  = 1'b0;
  wire logic   sck_pin;
  wire logic   nss_pin;
  wire logic   mosi_pin;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        sck_o;
  logic        sck_oe_o;
  logic        master_sample_o;
  logic [7:0]  rx_byte_o;
  logic        rx_valid_o;
  logic        master_role_o;
  logic        clock_phase_o;
  logic        clock_polarity_o;
  logic        port_enable_o;
  logic [7:0]  got_byte   = 8'h00;
  logic [31:0] rd;
  int          err_count  = 0;
  int          n_compared = 0;
  int          got_cnt    = 0;

  always #50 clk_i = ~clk_i;

  initial begin
    #3.3;
    forever #7.5 link_clk = ~link_clk;
  end

  spi_master_model partner (.sck_o(sck_pin), .nss_n_o(nss_pin), .mosi_o(mosi_pin));

  spi_config_status i_dut (
    .clk_i(clk_i), .rst_i(rst), .link_clk_i(link_clk),
    .adr_i(adr), .dat_i(dat_w), .dat_o(dat_o), .we_i(we), .sel_i(sel),
    .stb_i(stb), .cyc_i(cyc), .ack_o(ack_o),
    .sck_pin_i(sck_pin), .nss_pin_i(nss_pin), .mosi_pin_i(mosi_pin),
    .sck_o(sck_o), .sck_oe_o(sck_oe_o),
    .tx_pending_i(tx_pending), .tx_load_i(tx_load), .rx_read_i(rx_read),
    .sck_edge_next_i(edge_next), .master_sample_o(master_sample_o),
    .rx_byte_o(rx_byte_o), .rx_valid_o(rx_valid_o),
    .master_role_o(master_role_o), .clock_phase_o(clock_phase_o),
    .clock_polarity_o(clock_polarity_o), .port_enable_o(port_enable_o)
  );

  // new bytes are one-cycle pulses, so catch them as they pass
  always @(posedge clk_i) begin
    if (rx_valid_o === 1'b1) begin
      got_byte = rx_byte_o;
      got_cnt++;
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= a;
    dat_w <= d;
    sel   <= 4'hf;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1);
    r = dat_o;
    chk("bus ack latency", 32'h2, n);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic t_reset_regs;
    wb(1'b0, CFG, 32'h0, rd);
    chk("cfg after reset", {24'h0, spi_cfg_pkg::CFG_STATUS_RESET}, rd);
    wb(1'b0, CTRL, 32'h0, rd);
    chk("ctrl after reset", 32'h0, rd);
    wb(1'b1, CFG, 32'h0000008f, rd);
    wb(1'b0, CFG, 32'h0, rd);
    chk("read-only cfg bits", 32'h07, rd);
    wb(1'b1, 4'h8, 32'h000000ff, rd);
    wb(1'b0, 4'h8, 32'h0, rd);
    chk("unmapped read", 32'h0, rd);
  endtask : t_reset_regs

  task automatic t_master;
    wb(1'b1, CFG, 32'h40, rd);
    wb(1'b1, CTRL, 32'h1, rd);
    wb(1'b0, CFG, 32'h0, rd);
    chk("cfg in master", 32'h47, rd);
    chk("clock drive enable", 32'h1, {31'h0, sck_oe_o});
    chk("master role", 32'h1, {31'h0, master_role_o});
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      edge_next <= 1'b1;
      @(negedge clk_i);
      chk("master sample", i % 2, {31'h0, master_sample_o});
      @(posedge clk_i);
      edge_next <= 1'b0;
      @(negedge clk_i);
      chk("master clock", 1 - i % 2, {31'h0, sck_o});
    end
    wb(1'b1, CTRL, 32'h0, rd);
    wb(1'b1, CFG, 32'h0, rd);
    chk("clock drive off", 32'h0, {31'h0, sck_oe_o});
  endtask : t_master

  task automatic t_slave(input int k, input logic [7:0] data);
    logic        ph;
    logic        pol;
    logic [31:0] mask;
    int          n0;
    int          n;
    ph   = k[0];
    pol  = k[1];
    mask = 32'hff;
    wb(1'b1, CTRL, 32'h0, rd);
    wb(1'b1, CFG, {26'h0, ph, pol, 4'h0}, rd);
    wb(1'b1, CTRL, 32'h1, rd);
    chk("phase out", {31'h0, ph}, {31'h0, clock_phase_o});
    chk("polarity out", {31'h0, pol}, {31'h0, clock_polarity_o});
    chk("port enable out", 32'h1, {31'h0, port_enable_o});
    tx_pending <= (k == 3);
    partner.select_dev(pol);
    repeat (10) @(posedge clk_i);
    wb(1'b0, CFG, 32'h0, rd);
    chk("cfg selected", {26'h0, ph, pol, 4'b1001}, rd & 32'hfd);
    n0 = got_cnt;
    partner.xfer(data, ph, pol);
    for (n = 0; n < 40 && got_cnt == n0; n++) @(posedge clk_i);
    chk("received byte", {24'h0, data}, {24'h0, got_byte});
    repeat (6) @(posedge clk_i);
    wb(1'b0, CFG, 32'h0, rd);
    chk("cfg after byte", {26'h0, ph, pol, 2'b10, ph & (k != 3), 1'b0} & mask, rd & mask);
    @(posedge clk_i);
    rx_read <= 1'b1;
    @(posedge clk_i);
    rx_read <= 1'b0;
    wb(1'b0, CFG, 32'h0, rd);
    chk("rx empty after read", 32'h1, {31'h0, rd[0]});
    if (k == 1) begin
      @(posedge clk_i);
      tx_load <= 1'b1;
      @(posedge clk_i);
      tx_load <= 1'b0;
      repeat (3) @(posedge clk_i);
      wb(1'b0, CFG, 32'h0, rd);
      chk("shifter empty after load", 32'h0, {31'h0, rd[1]});
    end
    partner.deselect;
    tx_pending <= 1'b0;
    repeat (10) @(posedge clk_i);
    wb(1'b0, CFG, 32'h0, rd);
    chk("deselected flags", 32'h1, {30'h0, rd[3:2]});
  endtask : t_slave

  task automatic summarize;
    if (err_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  initial begin
    logic [7:0] pat [4];
    pat = '{8'ha5, 8'h3c, 8'h81, 8'h7e};
    repeat (16) @(posedge clk_i);
    rst <= 1'b0;
    t_reset_regs();
    t_master();
    for (int k = 0; k < 4; k++) t_slave(k, pat[k]);
    summarize();
  end

  // the run needs well under a third of this span
  initial begin
    #2000000;
    err_count++;
    summarize();
  end
endmodule : spi_config_status_bits_bench
`default_nettype wire
